// ==== hdl/table_write_and_zero_skip_exec.v ====
// Execution of the table-write and test-file-skip-if-zero instructions
//
// What this block does
// - Low two opcode bits pick pointer update
// - Pointer is 21-bit byte address
// - Pointer bit zero selects low/high byte
// - Table write: two cycles, latch to holding
// - Zero operand discards prefetch, runs NOP
// - Skip over 2/3-word instruction costs 3/4
// - Bank bit picks access bank or bank register
// - Extended, access, operand<=95 means indexed
// - Extended features off after reset
//
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`include "table_latch_store_op_test_file_skip_if_zero_defs.vh"
module table_write_and_zero_skip_exec #(
   parameter PTR_W  = 21,
   parameter BANK_W = 4
) (
   input  wire              clk,
   input  wire              rst_n,
   // Register port
   input  wire [3:0]        regAddr,
   input  wire [7:0]        regWrData,
   input  wire              regWr,
   input  wire              regRd,
   output reg  [7:0]        regRdData,
   // Instruction from the fetch pipeline
   input  wire              instrValid,
   input  wire [15:0]       instrWord,
   input  wire [1:0]        nextWords,
   output wire              instrReady,
   output wire [1:0]        instrPhase,
   output wire              busy,
   output wire              discardFetch,
   // Data register file
   input  wire [BANK_W+7:0] indexBase,
   output reg  [BANK_W+7:0] fileAddr,
   output reg               fileRead,
   input  wire [7:0]        fileData,
   // Holding register write
   output reg               holdWr,
   output reg  [PTR_W-1:0]  holdAddr,
   output reg               holdHighByte,
   output reg  [7:0]        holdData
);

   localparam ST_IDLE = 3'd0;
   localparam ST_TW1  = 3'd1;
   localparam ST_TW2  = 3'd2;
   localparam ST_ZT   = 3'd3;
   localparam ST_SKIP = 3'd4;

   reg  [2:0]        state_reg;
   reg  [2:0]        state_next;
   reg  [1:0]        phase_reg;
   reg  [1:0]        mode_reg;
   reg  [1:0]        skipLeft_reg;
   reg               zero_reg;
   reg               lastSkip_reg;
   reg               lastIndexed_reg;
   reg  [7:0]        latch_reg;
   reg  [PTR_W-1:0]  ptr_reg;
   reg  [PTR_W-1:0]  ptr_next;
   reg  [7:0]        bank_reg;
   reg  [7:0]        config_reg;
   wire [PTR_W-1:0]  ptrStepped;
   wire [23:0]       ptrWide;
   wire              isTableWrite;
   wire              isZeroTest;
   wire              take;
   wire              extEnable;
   wire              useIndexed;
   wire              stepUp;
   wire              stepDown;
   wire [7:0]        operand;

   ////////////////////////////////////////////////////////////////////////////
   // Decode

   assign isTableWrite = (instrWord & `TW_OPC_MASK) == `TW_OPC_VALUE;
   assign isZeroTest   = (instrWord & `ZT_OPC_MASK) == `ZT_OPC_VALUE;
   assign instrReady   = (state_reg == ST_IDLE) && (phase_reg == `PH_DECODE);
   assign take         = instrReady && instrValid;
   assign instrPhase   = phase_reg;
   assign busy         = state_reg != ST_IDLE;
   assign discardFetch = state_reg == ST_SKIP;
   assign extEnable    = config_reg[`CFG_EXT_BIT];
   assign operand      = instrWord[7:0];
   assign useIndexed   = !instrWord[`ZT_BANK_BIT] && extEnable
                         && (operand <= `INDEXED_MAX);

   // Operand address for the zero test
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fileAddr        <= {(BANK_W+8){1'b0}};
         lastIndexed_reg <= 1'b0;
      end else if (take && isZeroTest) begin
         lastIndexed_reg <= useIndexed;
         if (instrWord[`ZT_BANK_BIT]) begin
            fileAddr <= {bank_reg[BANK_W-1:0], operand};
         end else if (useIndexed) begin
            fileAddr <= indexBase + {{BANK_W{1'b0}}, operand};
         end else if (operand <= `INDEXED_MAX) begin
            fileAddr <= {{BANK_W{1'b0}}, operand};
         end else begin
            fileAddr <= {{BANK_W{1'b1}}, operand};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer: four clock phases make one instruction cycle

   assign stepUp   = ((state_reg == ST_TW1) && (mode_reg == `MODE_PRE_INC))
                     || ((state_reg == ST_TW2) && (mode_reg == `MODE_POST_INC));
   assign stepDown = (state_reg == ST_TW2) && (mode_reg == `MODE_POST_DEC);

   table_pointer_step #(
      .PTR_W    (PTR_W)
   ) stepper (
      .ptrIn    (ptr_reg),
      .stepUp   (stepUp),
      .stepDown (stepDown),
      .ptrOut   (ptrStepped)
   );

   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (take && isTableWrite) begin
               state_next = ST_TW1;
            end else if (take && isZeroTest) begin
               state_next = ST_ZT;
            end
         end
         ST_TW1: begin
            if (phase_reg == `PH_WRITE) begin
               state_next = ST_TW2;
            end
         end
         ST_TW2: begin
            if (phase_reg == `PH_WRITE) begin
               state_next = ST_IDLE;
            end
         end
         ST_ZT: begin
            if (phase_reg == `PH_WRITE) begin
               state_next = zero_reg ? ST_SKIP : ST_IDLE;
            end
         end
         ST_SKIP: begin
            if ((phase_reg == `PH_WRITE) && (skipLeft_reg <= 2'd1)) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg    <= ST_IDLE;
         phase_reg    <= `PH_DECODE;
         mode_reg     <= `MODE_KEEP;
         skipLeft_reg <= 2'd0;
         zero_reg     <= 1'b0;
         lastSkip_reg <= 1'b0;
         fileRead     <= 1'b0;
      end else begin
         state_reg <= state_next;
         // The phase counter runs freely so instruction cycles stay aligned
         phase_reg <= (phase_reg == `PHASES) ? `PH_DECODE : phase_reg + 2'd1;
         fileRead  <= take && isZeroTest;
         if (take) begin
            mode_reg <= instrWord[1:0];
         end
         if ((state_reg == ST_ZT) && (phase_reg == `PH_READ)) begin
            zero_reg <= fileData == 8'h00;
         end
         if ((state_reg == ST_ZT) && (phase_reg == `PH_WRITE)) begin
            lastSkip_reg <= zero_reg;
            // A following one-word instruction costs one extra cycle
            skipLeft_reg <= (nextWords == 2'd0) ? 2'd1 : nextWords;
         end else if ((state_reg == ST_SKIP) && (phase_reg == `PH_WRITE)) begin
            skipLeft_reg <= skipLeft_reg - 2'd1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Holding register write; flash commit happens elsewhere

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         holdWr       <= 1'b0;
         holdAddr     <= `PTR_RESET;
         holdHighByte <= 1'b0;
         holdData     <= 8'h00;
      end else begin
         holdWr <= (state_reg == ST_TW2) && (phase_reg == `PH_WRITE);
         if ((state_reg == ST_TW2) && (phase_reg == `PH_READ)) begin
            holdData <= latch_reg;
         end
         if ((state_reg == ST_TW2) && (phase_reg == `PH_WRITE)) begin
            holdAddr     <= ptr_reg;
            holdHighByte <= ptr_reg[0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers; a pointer update from an executing write beats a software write

   always @* begin
      ptr_next = ptr_reg;
      if (regWr && (regAddr == `REG_PTR_LOW)) begin
         ptr_next[7:0] = regWrData;
      end
      if (regWr && (regAddr == `REG_PTR_HIGH)) begin
         ptr_next[15:8] = regWrData;
      end
      if (regWr && (regAddr == `REG_PTR_UPPER)) begin
         ptr_next[PTR_W-1:16] = regWrData[PTR_W-17:0];
      end
      if (phase_reg == `PH_WRITE && (stepUp || stepDown)) begin
         ptr_next = ptrStepped;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         latch_reg  <= `LATCH_RESET;
         ptr_reg    <= `PTR_RESET;
         bank_reg   <= `BANK_RESET;
         config_reg <= `CONFIG_RESET;
      end else begin
         ptr_reg <= ptr_next;
         if (regWr && (regAddr == `REG_LATCH)) begin
            latch_reg <= regWrData;
         end
         if (regWr && (regAddr == `REG_BANK)) begin
            bank_reg <= regWrData;
         end
         if (regWr && (regAddr == `REG_CONFIG)) begin
            config_reg <= {7'h00, regWrData[`CFG_EXT_BIT]};
         end
      end
   end

   assign ptrWide = {{(24-PTR_W){1'b0}}, ptr_reg};

   // Status flags do not change on a table write; only this view of block state
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         regRdData <= 8'h00;
      end else if (regRd) begin
         case (regAddr)
            `REG_LATCH:     regRdData <= latch_reg;
            `REG_PTR_LOW:   regRdData <= ptrWide[7:0];
            `REG_PTR_HIGH:  regRdData <= ptrWide[15:8];
            `REG_PTR_UPPER: regRdData <= ptrWide[23:16];
            `REG_BANK:      regRdData <= bank_reg;
            `REG_CONFIG:    regRdData <= config_reg;
            `REG_STATUS:    regRdData <= {4'h0, state_reg == ST_TW1 || state_reg == ST_TW2,
                                          lastIndexed_reg, lastSkip_reg, busy};
            default:        regRdData <= 8'h00;
         endcase
      end else begin
         regRdData <= 8'h00;
      end
   end

endmodule // table_write_and_zero_skip_exec

// ==== hdl/table_latch_store_op_test_file_skip_if_zero_defs.vh ====
// Constants for the table-write and zero-skip execution block
`ifndef TABLE_EXEC_DEFS_VH
`define TABLE_EXEC_DEFS_VH

// Register index map, one index per 8-bit register
`define REG_LATCH        4'h0
`define REG_PTR_LOW      4'h1
`define REG_PTR_HIGH     4'h2
`define REG_PTR_UPPER    4'h3
`define REG_BANK         4'h4
`define REG_CONFIG       4'h5
`define REG_STATUS       4'h6

// Reset values
`define LATCH_RESET      8'h00
`define PTR_RESET        21'h00_0000
`define BANK_RESET       8'h00
`define CONFIG_RESET     8'h00

// Field positions
`define CFG_EXT_BIT      0
`define ST_BUSY_BIT      0
`define ST_SKIP_BIT      1
`define ST_INDEXED_BIT   2
`define ST_TABLE_BIT     3

// Opcode patterns
`define TW_OPC_MASK      16'hFFFC
`define TW_OPC_VALUE     16'h000C
`define ZT_OPC_MASK      16'hFE00
`define ZT_OPC_VALUE     16'h6600
`define ZT_BANK_BIT      8

// Pointer update modes
`define MODE_KEEP        2'h0
`define MODE_POST_INC    2'h1
`define MODE_POST_DEC    2'h2
`define MODE_PRE_INC     2'h3

// Addressing
`define INDEXED_MAX      8'h5F
`define ACCESS_HI_BANK   4'hF

// Timing: clock phases per instruction cycle
`define PHASES           2'h3
`define PH_DECODE        2'h0
`define PH_READ          2'h1
`define PH_WRITE         2'h3

`endif

// ==== hdl/table_pointer_step.v ====
// Pointer increment / decrement unit for the table byte pointer
`timescale 1ns/100ps
module table_pointer_step #(
   parameter PTR_W = 21
) (
   input  wire [PTR_W-1:0] ptrIn,
   input  wire             stepUp,
   input  wire             stepDown,
   output reg  [PTR_W-1:0] ptrOut
);

   // Wraps at both ends of the byte space
   always @* begin
      if (stepUp) begin
         ptrOut = ptrIn + {{(PTR_W-1){1'b0}}, 1'b1};
      end else if (stepDown) begin
         ptrOut = ptrIn - {{(PTR_W-1){1'b0}}, 1'b1};
      end else begin
         ptrOut = ptrIn;
      end
   end

endmodule // table_pointer_step

// ==== sim/exec_checker_sva.sv ====
// Port assertions for the table-write and zero-skip execution block
`timescale 1ns/100ps
`include "table_latch_store_op_test_file_skip_if_zero_defs.vh"
module exec_checker #(
   parameter PTR_W  = 21,
   parameter BANK_W = 4
) (
   input wire              clk,
   input wire              rst_n,
   input wire [3:0]        regAddr,
   input wire [7:0]        regWrData,
   input wire              regWr,
   input wire              instrValid,
   input wire [15:0]       instrWord,
   input wire [1:0]        nextWords,
   input wire              instrReady,
   input wire              busy,
   input wire              discardFetch,
   input wire [BANK_W+7:0] indexBase,
   input wire [BANK_W+7:0] fileAddr,
   input wire              fileRead,
   input wire [7:0]        fileData,
   input wire              holdWr,
   input wire [PTR_W-1:0]  holdAddr,
   input wire              holdHighByte,
   input wire [7:0]        holdData
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic [7:0]        latchSh;
   logic [BANK_W-1:0] bankSh;
   logic              extSh;
   logic [1:0]        wordsSh;
   logic [4:0]        runCnt;
   wire twTake = instrValid && instrReady && ((instrWord & `TW_OPC_MASK) == `TW_OPC_VALUE);
   wire ztTake = instrValid && instrReady && ((instrWord & `ZT_OPC_MASK) == `ZT_OPC_VALUE);
   // Shadows of software-written state, so addresses can be predicted
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         latchSh <= 8'h00;
         bankSh <= '0;
         extSh <= 1'b0;
         wordsSh <= 2'h0;
         runCnt <= 5'h00;
      end else begin
         if (regWr && regAddr == `REG_LATCH) latchSh <= regWrData;
         if (regWr && regAddr == `REG_BANK) bankSh <= regWrData[BANK_W-1:0];
         if (regWr && regAddr == `REG_CONFIG) extSh <= regWrData[0];
         if (ztTake) wordsSh <= (nextWords == 2'h0) ? 2'h1 : nextWords;
         runCnt <= discardFetch ? runCnt + 5'h01 : 5'h00;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   chk_tw_store_time: assert property (twTake |=> !holdWr [*7] ##1 holdWr)
      else $error("table write store not in eighth cycle");
   chk_tw_busy_span: assert property (twTake |=> busy [*7] ##1 !busy)
      else $error("table write busy span wrong");
   chk_hold_byte: assert property (holdWr |-> holdHighByte == holdAddr[0])
      else $error("byte select differs from pointer bit zero");
   chk_hold_data: assert property (holdWr |-> holdData == latchSh)
      else $error("holding data differs from latch");
   chk_skip_start: assert property (
      ztTake ##1 (fileRead && fileData == 8'h00) |-> ##3 discardFetch)
      else $error("zero operand did not discard prefetch");
   chk_no_skip: assert property (
      ztTake ##1 (fileRead && fileData != 8'h00) |-> !discardFetch [*3] ##1 instrReady)
      else $error("nonzero operand not done in one cycle");
   chk_skip_len: assert property (
      $fell(discardFetch) |-> runCnt == {1'b0, wordsSh, 2'b00})
      else $error("skip length does not match next instruction size");
   chk_bank_addr: assert property (
      ztTake && instrWord[8] |=> fileAddr == {bankSh, $past(instrWord[7:0])})
      else $error("banked operand address wrong");
   chk_access_hi: assert property (
      ztTake && !instrWord[8] && instrWord[7:0] > `INDEXED_MAX
      |=> fileAddr == {{BANK_W{1'b1}}, $past(instrWord[7:0])})
      else $error("access bank upper address wrong");
   chk_access_lo: assert property (
      ztTake && !instrWord[8] && !extSh && instrWord[7:0] <= `INDEXED_MAX
      |=> fileAddr == {{BANK_W{1'b0}}, $past(instrWord[7:0])})
      else $error("direct access operand address wrong");
   chk_indexed: assert property (
      ztTake && !instrWord[8] && extSh && instrWord[7:0] <= `INDEXED_MAX
      |=> fileAddr == $past(indexBase) + $past(instrWord[7:0]))
      else $error("indexed operand address wrong");
   cov_tw: cover property (twTake);
   cov_skip: cover property ($fell(discardFetch));
   cov_index: cover property (ztTake && !instrWord[8] && extSh);
endmodule // exec_checker
bind table_write_and_zero_skip_exec exec_checker #(.PTR_W(PTR_W), .BANK_W(BANK_W)) chk (
   .clk, .rst_n, .regAddr, .regWrData, .regWr, .instrValid, .instrWord, .nextWords,
   .instrReady, .busy, .discardFetch, .indexBase, .fileAddr, .fileRead, .fileData,
   .holdWr, .holdAddr, .holdHighByte, .holdData);

// ==== sim/file_reg_model.sv ====
// Data register file model answering zero-test operand reads
`timescale 1ns/100ps
module file_reg_model (
   input  wire        clk,
   input  wire [11:0] fileAddr,
   input  wire        fileRead,
   output wire [7:0]  fileData
);
   logic [7:0] mem [0:4095];
   logic [7:0] lastVal = 8'h00;
   initial for (int i = 0; i < 4096; i++) mem[i] = 8'hA5;
   task automatic setByte(input logic [11:0] a, input logic [7:0] v);
      mem[a] = v;
   endtask
   always @(posedge clk) if (fileRead) lastVal <= mem[fileAddr];
   // Outside a read the bus shows no stale value
   assign fileData = fileRead ? mem[fileAddr] : ~lastVal;
endmodule // file_reg_model

// ==== sim/tb_table_write_and_zero_skip_exec.sv ====
// Self-checking bench for the table-write and zero-skip block
`timescale 1ns/100ps
`include "table_latch_store_op_test_file_skip_if_zero_defs.vh"
module tb_table_write_and_zero_skip_exec;
   logic clk = 1'b0, rst_n = 1'b0, regWr = 1'b0, regRd = 1'b0, instrValid = 1'b0;
   logic [3:0] regAddr = 4'h0;
   logic [7:0] regWrData = 8'h00, regRdData, fileData, holdData;
   logic [15:0] instrWord = 16'h0000;
   logic [1:0] nextWords = 2'h1, instrPhase;
   logic instrReady, busy, discardFetch, fileRead, holdWr, holdHighByte, idx;
   logic [11:0] indexBase = 12'h100, fileAddr;
   logic [20:0] holdAddr, p, hAddr;
   logic [20:0] startP [4] = '{21'h0_A356, 21'h1F_FFFF, 21'h00_0000, 21'h1_389A};
   logic [15:0] zw [6] = '{16'h6712, 16'h6712, 16'h6620, 16'h665F, 16'h6660, 16'h665F};
   logic [11:0] za [6] = '{12'h312, 12'h312, 12'h020, 12'h15F, 12'hF60, 12'h15F};
   logic [1:0] zn [6] = '{2'h1, 2'h1, 2'h2, 2'h3, 2'h0, 2'h0};
   bit zz [6] = '{0, 1, 1, 1, 0, 1};
   bit ze [6] = '{0, 0, 0, 1, 1, 1};
   int errCount = 0, checkCount = 0, n, d, cyc;
   always #12.5 clk = ~clk;
   table_write_and_zero_skip_exec dut (.clk, .rst_n, .regAddr, .regWrData, .regWr, .regRd,
      .regRdData, .instrValid, .instrWord, .nextWords, .instrReady, .instrPhase, .busy,
      .discardFetch, .indexBase, .fileAddr, .fileRead, .fileData, .holdWr, .holdAddr,
      .holdHighByte, .holdData);
   file_reg_model model (.clk, .fileAddr, .fileRead, .fileData);
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checkCount++;
      if (seen !== exp) begin
         errCount++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic endSim;
      $display("checks %0d errors %0d", checkCount, errCount);
      if (errCount == 0 && checkCount > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Strobes drop for a cycle between accesses: simpler than back-to-back
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      regAddr <= a;
      regWrData <= v;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 check(what, regRdData, exp);
      @(posedge clk);
   endtask
   // Offer held from a rising edge until ready is seen high at an edge
   task automatic issue(input logic [15:0] w);
      int k;
      k = 0;
      instrWord <= w;
      instrValid <= 1'b1;
      do begin
         @(posedge clk);
         k++;
      end while (instrReady !== 1'b1 && k < 64);
      instrValid <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      for (int a = 0; a < 8; a++) rd(a, 8'h00, "reset value");
      for (int m = 0; m < 4; m++) begin
         p = startP[m];
         wr(`REG_PTR_LOW, p[7:0]);
         wr(`REG_PTR_HIGH, p[15:8]);
         wr(`REG_PTR_UPPER, {3'b000, p[20:16]});
         wr(`REG_LATCH, 8'h55 + m);
         issue(16'h000C | m);
         repeat (7) @(posedge clk);
         hAddr = (m == 3) ? p + 21'h1 : p;
         #1 check("hold strobe", holdWr, 1);
         check("hold addr", holdAddr, hAddr);
         check("hold byte", holdHighByte, hAddr[0]);
         check("hold data", holdData, 8'h55 + m);
         check("phase", instrPhase, `PH_DECODE);
         @(posedge clk);
         p = (m == 0) ? p : (m == 2) ? p - 21'h1 : p + 21'h1;
         rd(`REG_PTR_LOW, p[7:0], "ptr low");
         rd(`REG_PTR_HIGH, p[15:8], "ptr high");
         rd(`REG_PTR_UPPER, {3'b000, p[20:16]}, "ptr upper");
      end
      wr(`REG_BANK, 8'h03);
      rd(`REG_BANK, 8'h03, "bank");
      for (int i = 0; i < 6; i++) begin
         model.setByte(za[i], zz[i] ? 8'h00 : 8'h3C);
         wr(`REG_CONFIG, {7'h00, ze[i]});
         nextWords <= zn[i];
         issue(zw[i]);
         #1 check("file addr", fileAddr, za[i]);
         check("file read", fileRead, 1);
         n = 0;
         d = 0;
         while (instrReady !== 1'b1 && n < 40) begin
            @(posedge clk);
            #1 n++;
            d += discardFetch;
         end
         cyc = zz[i] ? 4 + 4 * ((zn[i] == 2'h0) ? 1 : zn[i]) : 4;
         check("cycles", n + 1, cyc);
         check("discarded", d, cyc - 4);
         idx = ze[i] && !zw[i][8] && zw[i][7:0] <= 8'h5F;
         @(posedge clk);
         rd(`REG_STATUS, {5'h00, idx, zz[i], 1'b0}, "status");
      end
      endSim;
   end
   initial begin
      repeat (5000) @(posedge clk);
      errCount++;
      endSim;
   end
endmodule // tb_table_write_and_zero_skip_exec
